// ==== rtl/fcui_pkg.sv ====
// Package for the flash command controller: command codes, timing and op kinds.
// Assumes a byte-wide flash device on an asynchronous SRAM-style bus.
`default_nettype none
package fcui_pkg;
	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
	localparam logic [7:0] CMD_READ_ID      = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
	localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
	localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
	localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
	localparam logic [7:0] CMD_LOCK_BLOCK   = 8'h01;
	localparam logic [7:0] CMD_LOCK_MASTER  = 8'hf1;
	// ==========================================================
	// Status value loaded on leaving deep power-down
	localparam logic [7:0] STATUS_AFTER_WAKE = 8'h80;
	// ==========================================================
	// Bus timing, in ns, and derived cycle counts at 20 MHz
	localparam int CLK_PERIOD_NS  = 50;
	localparam int T_SETUP_NS     = 50;
	localparam int T_STROBE_NS    = 100;
	localparam int T_READ_NS      = 150;
	localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC   = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_W     = 21;
	// ==========================================================
	// Operations a user may request
	typedef enum logic [3:0] {
		OP_READ_ARRAY,
		OP_READ_ID,
		OP_READ_STATUS,
		OP_CLEAR_STATUS,
		OP_ERASE,
		OP_PROGRAM,
		OP_SUSPEND,
		OP_RESUME,
		OP_LOCK_BLOCK,
		OP_LOCK_MASTER,
		OP_UNLOCK_ALL,
		OP_READ
	} fcui_op_t;
endpackage : fcui_pkg
`default_nettype wire

// ==== rtl/fcui_cyc_if.sv ====
// Interface carrying one flash bus cycle between sequencer and pin engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface fcui_cyc_if;
	logic                        start;   // One-cycle request
	logic                        is_write; // Write cycle when high
	logic [fcui_pkg::ADDR_W-1:0] addr;    // Cycle address
	logic [7:0]                  wdata;   // Write byte
	logic [7:0]                  rdata;   // Read byte
	logic                        done;    // One-cycle completion
	logic                        busy;    // Cycle in progress
	modport seq (output start, is_write, addr, wdata, input rdata, done, busy);
	modport eng (input start, is_write, addr, wdata, output rdata, done, busy);
endinterface : fcui_cyc_if
`default_nettype wire

// ==== rtl/fcui_bus_cycle.sv ====
// Pin engine: runs one write or read cycle on the flash strobes.
// Assumes data pins already synchronised by the top for reads.
`timescale 1ns/1ps
`default_nettype none
module fcui_bus_cycle (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// Cycle request
	fcui_cyc_if.eng                          cyc,
	// Synchronised data in
	input  wire logic [7:0]                  data_in_s,
	// Flash strobes
	output var  logic                        chip_sel_n_q,
	output var  logic                        out_en_n_q,
	output var  logic                        write_en_n_q,
	output var  logic [fcui_pkg::ADDR_W-1:0] addr_q,
	output var  logic [7:0]                  data_out_q,
	output var  logic                        data_oe_n_q
);
	// ==========================================================
	// Phases of a cycle
	typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fcui_ph_t;
	fcui_ph_t   ph_q;      // Current phase
	logic [3:0] cnt_q;     // Phase counter
	logic       wr_q;      // Latched direction
	logic [7:0] rdata_q;   // Captured read byte
	logic       done_q;    // Completion pulse

	// Phase sequencing; write releases write enable before chip select so capture edge is ours
	always_ff @(posedge clk)
	begin
		done_q <= 1'b0;
		if (reset)
		begin
			ph_q         <= PH_IDLE;
			cnt_q        <= 4'h0;
			wr_q         <= 1'b0;
			chip_sel_n_q <= 1'b1;
			out_en_n_q   <= 1'b1;
			write_en_n_q <= 1'b1;
			addr_q       <= '0;
			data_out_q   <= 8'h00;
			data_oe_n_q  <= 1'b1;
			rdata_q      <= 8'h00;
		end
		else
		begin
			unique case (ph_q)
				PH_IDLE:
				begin
					if (cyc.start)
					begin
						ph_q         <= PH_SETUP;
						cnt_q        <= 4'(fcui_pkg::SETUP_CYC);
						wr_q         <= cyc.is_write;
						addr_q       <= cyc.addr;
						data_out_q   <= cyc.wdata;
						chip_sel_n_q <= 1'b0;
						// Drive data only on writes; output enable stays high
						data_oe_n_q  <= ~cyc.is_write;
					end
				end
				PH_SETUP:
				begin
					if (cnt_q <= 4'h1)
					begin
						ph_q  <= PH_STROBE;
						cnt_q <= wr_q ? 4'(fcui_pkg::STROBE_CYC) : 4'(fcui_pkg::READ_CYC);
						// Write pulls write enable only, read pulls output enable
						write_en_n_q <= ~wr_q;
						out_en_n_q   <= wr_q;
					end
					else
						cnt_q <= cnt_q - 4'h1;
				end
				PH_STROBE:
				begin
					if (cnt_q <= 4'h1)
					begin
						ph_q         <= PH_HOLD;
						write_en_n_q <= 1'b1;
						out_en_n_q   <= 1'b1;
						if (!wr_q)
							rdata_q <= data_in_s;
					end
					else
						cnt_q <= cnt_q - 4'h1;
				end
				PH_HOLD:
				begin
					// Chip select rises after write enable, so the first edge is write enable
					ph_q         <= PH_IDLE;
					chip_sel_n_q <= 1'b1;
					data_oe_n_q  <= 1'b1;
					done_q       <= 1'b1;
				end
			endcase
		end
	end

	assign cyc.rdata = rdata_q;
	assign cyc.done  = done_q;
	assign cyc.busy  = (ph_q != PH_IDLE);

	// ==========================================================
	// Checks
	a_write_oe_high: assert property (@(posedge clk) disable iff (reset)
		!write_en_n_q |-> out_en_n_q)
		else $error("write strobe with output enable low");
	a_we_before_ce: assert property (@(posedge clk) disable iff (reset)
		$rose(write_en_n_q) |-> !chip_sel_n_q)
		else $error("chip select rose before write enable");
	a_drive_no_oe: assert property (@(posedge clk) disable iff (reset)
		!data_oe_n_q |-> out_en_n_q)
		else $error("data driven while output enable low");
endmodule : fcui_bus_cycle
`default_nettype wire

// ==== rtl/fcui_host.sv ====
// Host controller that drives a byte-wide flash through its strobes.
// Assumes one 20 MHz clock and a device on the asynchronous SRAM-style bus.
//
// Contract
// - Command write: write and select low, output high
// - Code FFH selects read array
// - Code 90H selects identifier mode
// - Code 70H selects status mode
// - Erase is 20H then D0H in block
// - Program second write: address and byte
// - Host issues only defined codes
// - Code 50H clears error bits
`timescale 1ns/1ps
`default_nettype none
module fcui_host (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// User request port
	input  wire logic                        req_valid,
	input  wire fcui_pkg::fcui_op_t          req_op,
	input  wire logic [fcui_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [7:0]                  req_data,
	output var  logic                        req_ready_q,
	output var  logic                        resp_valid_q,
	output var  logic [7:0]                  resp_data_q,
	output var  logic                        device_ready_q,
	// Power-down control
	input  wire logic                        powerdown_req,
	// Flash pins
	output var  logic                        chip_sel_n_q,
	output var  logic                        out_en_n_q,
	output var  logic                        write_en_n_q,
	output var  logic                        reset_powerdown_n_q,
	output var  logic [fcui_pkg::ADDR_W-1:0] addr_q,
	output var  logic [7:0]                  data_lines_o_q,
	output var  logic                        data_lines_oe_n_q,
	input  wire logic [7:0]                  data_lines_i,
	input  wire logic                        ready_busy_n
);
	// ==========================================================
	// Pin synchronisers
	logic [7:0] data_m_q, data_s_q; // Data two-stage sync
	logic       rb_m_q, rb_s_q;     // Ready/busy two-stage sync
	always_ff @(posedge clk)
	begin
		data_m_q <= data_lines_i;
		data_s_q <= data_m_q;
		rb_m_q   <= ready_busy_n;
		rb_s_q   <= rb_m_q;
	end

	// ==========================================================
	// Pin engine
	fcui_cyc_if cyc ();
	fcui_bus_cycle u_bus (
		.clk          (clk),
		.reset        (reset),
		.cyc          (cyc),
		.data_in_s    (data_s_q),
		.chip_sel_n_q (chip_sel_n_q),
		.out_en_n_q   (out_en_n_q),
		.write_en_n_q (write_en_n_q),
		.addr_q       (addr_q),
		.data_out_q   (data_lines_o_q),
		.data_oe_n_q  (data_lines_oe_n_q)
	);

	// ==========================================================
	// Sequencer
	typedef enum logic [2:0] {S_IDLE, S_FIRST, S_SECOND, S_READ, S_DOWN} fcui_st_t;
	fcui_st_t                    st_q;       // Sequencer state
	logic                        two_q;      // Second write pending
	logic [7:0]                  first_q;    // First byte
	logic [7:0]                  second_q;   // Second byte
	logic [fcui_pkg::ADDR_W-1:0] a_q;        // Held address
	logic                        start_q;    // Cycle request pulse
	logic                        wr_q;       // Cycle direction
	logic [7:0]                  code_d;     // First code for request
	logic [7:0]                  code2_d;    // Second code for request
	logic                        two_d;      // Request is two writes
	logic                        rd_d;       // Request is a plain read

	// Map request to codes; all are defined codes except the program second write, which is req_data
	always_comb
	begin
		code_d  = fcui_pkg::CMD_READ_ARRAY;
		code2_d = 8'h00;
		two_d   = 1'b0;
		rd_d    = 1'b0;
		unique case (req_op)
			fcui_pkg::OP_READ_ARRAY:   code_d = fcui_pkg::CMD_READ_ARRAY;
			fcui_pkg::OP_READ_ID:      code_d = fcui_pkg::CMD_READ_ID;
			fcui_pkg::OP_READ_STATUS:  code_d = fcui_pkg::CMD_READ_STATUS;
			fcui_pkg::OP_CLEAR_STATUS: code_d = fcui_pkg::CMD_CLEAR_STATUS;
			fcui_pkg::OP_SUSPEND:      code_d = fcui_pkg::CMD_SUSPEND;
			fcui_pkg::OP_RESUME:       code_d = fcui_pkg::CMD_CONFIRM;
			fcui_pkg::OP_ERASE:
			begin
				// Both writes carry the block address
				code_d  = fcui_pkg::CMD_ERASE_SETUP;
				code2_d = fcui_pkg::CMD_CONFIRM;
				two_d   = 1'b1;
			end
			fcui_pkg::OP_PROGRAM:
			begin
				// Standard setup; second write is the user byte
				code_d  = fcui_pkg::CMD_PROG_SETUP;
				code2_d = req_data;
				two_d   = 1'b1;
			end
			fcui_pkg::OP_LOCK_BLOCK:
			begin
				code_d  = fcui_pkg::CMD_LOCK_SETUP;
				code2_d = fcui_pkg::CMD_LOCK_BLOCK;
				two_d   = 1'b1;
			end
			fcui_pkg::OP_LOCK_MASTER:
			begin
				code_d  = fcui_pkg::CMD_LOCK_SETUP;
				code2_d = fcui_pkg::CMD_LOCK_MASTER;
				two_d   = 1'b1;
			end
			fcui_pkg::OP_UNLOCK_ALL:
			begin
				code_d  = fcui_pkg::CMD_LOCK_SETUP;
				code2_d = fcui_pkg::CMD_CONFIRM;
				two_d   = 1'b1;
			end
			fcui_pkg::OP_READ:         rd_d = 1'b1;
			default:                   rd_d = 1'b1;
		endcase
	end

	// Request handling and cycle issue
	always_ff @(posedge clk)
	begin
		start_q      <= 1'b0;
		resp_valid_q <= 1'b0;
		if (reset)
		begin
			st_q        <= S_IDLE;
			two_q       <= 1'b0;
			first_q     <= 8'h00;
			second_q    <= 8'h00;
			a_q         <= '0;
			wr_q        <= 1'b0;
			req_ready_q <= 1'b0;
			resp_data_q <= 8'h00;
		end
		else
		begin
			unique case (st_q)
				S_IDLE:
				begin
					req_ready_q <= ~powerdown_req;
					if (powerdown_req)
						st_q <= S_DOWN;
					else if (req_valid && req_ready_q)
					begin
						req_ready_q <= 1'b0;
						a_q         <= req_addr;
						first_q     <= code_d;
						second_q    <= code2_d;
						two_q       <= two_d;
						wr_q        <= ~rd_d;
						start_q     <= 1'b1;
						st_q        <= rd_d ? S_READ : S_FIRST;
					end
				end
				S_FIRST:
				begin
					if (cyc.done)
					begin
						if (two_q)
						begin
							two_q   <= 1'b0;
							start_q <= 1'b1;
							st_q    <= S_SECOND;
						end
						else
							st_q <= S_IDLE;
					end
				end
				S_SECOND:
				begin
					if (cyc.done)
						st_q <= S_IDLE;
				end
				S_READ:
				begin
					// Data is whatever mode the device holds: array, id or status
					if (cyc.done)
					begin
						resp_data_q  <= cyc.rdata;
						resp_valid_q <= 1'b1;
						st_q         <= S_IDLE;
					end
				end
				S_DOWN:
				begin
					// Device wakes in read array with status preset
					if (!powerdown_req)
						st_q <= S_IDLE;
				end
			endcase
		end
	end

	assign cyc.start    = start_q;
	assign cyc.is_write = wr_q;
	assign cyc.addr     = a_q;
	assign cyc.wdata    = (st_q == S_SECOND) ? second_q : first_q;

	// Power-down pin and ready mirror
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			reset_powerdown_n_q <= 1'b0;
			device_ready_q      <= 1'b0;
		end
		else
		begin
			reset_powerdown_n_q <= !(st_q == S_DOWN);
			// Busy while algorithm runs, so a read array would be ignored
			device_ready_q      <= rb_s_q;
		end
	end

	// ==========================================================
	// Checks
	a_powerdown_pin: assert property (@(posedge clk) disable iff (reset)
		(st_q == S_DOWN) |=> !reset_powerdown_n_q)
		else $error("power-down pin not low in power-down");
	a_second_code: assert property (@(posedge clk) disable iff (reset)
		(st_q == S_FIRST) && cyc.done && two_q |=> (st_q == S_SECOND) && start_q)
		else $error("second write not issued");
	a_read_resp: assert property (@(posedge clk) disable iff (reset)
		(st_q == S_READ) && cyc.done |=> resp_valid_q)
		else $error("read answer missing");
	a_no_drive_rd: assert property (@(posedge clk) disable iff (reset)
		!out_en_n_q |-> data_lines_oe_n_q)
		else $error("host drives data during read");
	a_idle_deselect: assert property (@(posedge clk) disable iff (reset)
		(st_q == S_DOWN) && !cyc.busy |-> chip_sel_n_q)
		else $error("selected while powered down");
	c_erase: cover property (@(posedge clk) (st_q == S_SECOND) && cyc.done);
	c_read: cover property (@(posedge clk) resp_valid_q);
	c_down: cover property (@(posedge clk) $fell(reset_powerdown_n_q));
endmodule : fcui_host
`default_nettype wire

// ==== dv/fcui_flash_model.sv ====
// Behavioural byte-wide flash: command port, array, identifier, status, locks.
// Assumes host strobes on its pins and supply levels set by the bench.
`timescale 1ns/1ps
`default_nettype none
module fcui_flash_model #(
	parameter logic [7:0] MAKER_ID  = 8'h3c, // Arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value
	parameter int         BUSY_NS   = 4000   // Algorithm run time
) (
	// Strobes and address
	input  wire logic                        ce_n,
	input  wire logic                        oe_n,
	input  wire logic                        we_n,
	input  wire logic                        reset_powerdown_n,
	input  wire logic [fcui_pkg::ADDR_W-1:0] a,
	// Host data side
	input  wire logic [7:0]                  hd,
	input  wire logic                        hd_oe_n,
	// Supply levels
	input  wire logic                        vpp_ok,
	input  wire logic                        hv,
	// Towards host
	output wire logic [7:0]                  dq,
	output var  logic                        ready_busy_n
);
	// ==========================================================
	// Storage
	logic [7:0]  mem [512];     // Block and low address nibble only
	logic [7:0]  st   = 8'h80;  // Status, top bit replaced by ready
	logic [7:0]  pend = 8'h00;  // Pending setup code
	logic [7:0]  v;
	logic [7:0]  last = 8'h00;
	logic [31:0] lk   = '0;     // Block lock bits
	logic        ml   = 1'b0;   // Master lock
	int          md   = 0;      // 0 array, 1 identifier, 2 status
	event        go;
	wire  [4:0]  b  = a[20:16];
	wire         rd = !ce_n && !oe_n && we_n && reset_powerdown_n;
	initial
	begin
		ready_busy_n = 1'b1;
		foreach (mem[i])
			mem[i] = 8'hff;
	end
	// ==========================================================
	// Read data; a floating bus shows the inverse, not a stale match
	always @*
		case (md)
			1: v = a[1:0] == 2'h0 ? MAKER_ID : a[1:0] == 2'h1 ? DEVICE_ID :
				{7'h0, a[0] ? ml : lk[b]};
			2: v = {ready_busy_n, st[6:0]};
			default: v = mem[{b, a[3:0]}];
		endcase
	always @*
		if (rd)
			last = v;
	assign dq = !hd_oe_n ? hd : rd ? v : ~last;
	// ==========================================================
	// Wake-up and busy timing
	always @(posedge reset_powerdown_n)
	begin
		md   = 0;
		st   = 8'h80;
		pend = 8'h00;
	end
	always @(negedge reset_powerdown_n)
		ready_busy_n = 1'b1;
	always @(go)
	begin
		ready_busy_n = 1'b0;
		#(BUSY_NS);
		ready_busy_n = 1'b1;
	end
	// Capture on whichever strobe rises first
	always @(posedge we_n or posedge ce_n)
		if (oe_n && reset_powerdown_n && (!ce_n || !we_n))
			cmd(hd);
	task automatic cmd(input logic [7:0] d);
		logic ok;
		ok = !lk[b] || hv;
		if (pend != 8'h00)
		begin
			if (!vpp_ok)
				st[3] = 1'b1;
			else if (pend == 8'h60)
			begin
				if (d == 8'h01 && (!ml || hv)) lk[b] = 1'b1;
				else if (d == 8'hf1 && hv) ml = 1'b1;
				else if (d == 8'hd0 && (!ml || hv)) lk = '0;
				else st[4] = 1'b1;
			end
			else if (!ok)
				st[1] = 1'b1;
			else if (pend != 8'h20)
				mem[{b, a[3:0]}] &= d;
			else
				for (int j = 0; j < 16; j++)
					mem[{b, 4'(j)}] = 8'hff;
			->go;
			pend = 8'h00;
			md   = 2;
		end
		else
		begin
			case (d)
				8'hff: if (ready_busy_n) md = 0;
				8'h90: md = 1;
				8'h70: md = 2;
				8'h50: st = 8'h80;
				default: md = 2;
			endcase
			if (d inside {8'h20, 8'h40, 8'h10, 8'h60})
				pend = d;
		end
	endtask : cmd
endmodule : fcui_flash_model
`default_nettype wire

// ==== dv/test_flash_command_user_interface.sv ====
// Self-checking bench: host controller against the behavioural flash.
// Assumes package, interface, design and flash model compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_flash_command_user_interface;
	// ==========================================================
	// Stimulus and observed signals
	localparam int AW = fcui_pkg::ADDR_W;
	logic clk = 0, reset = 1, req_valid = 0, powerdown_req = 0, vpp_ok = 1, hv = 0;
	fcui_pkg::fcui_op_t req_op = fcui_pkg::OP_READ;
	logic [AW-1:0] req_addr = '0, addr_q;
	logic [7:0]    req_data = '0, resp_data_q, d_o, d_i;
	logic          req_ready_q, resp_valid_q, device_ready_q;
	logic          cs_n, oe_n, we_n, pwrdn_n, d_oe_n, rdy_n;
	logic [7:0]    exp_q [$];    // Expected read results, oldest first
	int            mismatches = 0, checks = 0, cyc = 0;
	logic [31:0]   rnd = 32'd2067;
	logic [AW-1:0] av [3];
	logic [7:0]    dv [3];
	always #25 clk = ~clk;
	fcui_host i_dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_op(req_op),
		.req_addr(req_addr), .req_data(req_data), .req_ready_q(req_ready_q),
		.resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q),
		.device_ready_q(device_ready_q), .powerdown_req(powerdown_req),
		.chip_sel_n_q(cs_n), .out_en_n_q(oe_n), .write_en_n_q(we_n),
		.reset_powerdown_n_q(pwrdn_n), .addr_q(addr_q), .data_lines_o_q(d_o),
		.data_lines_oe_n_q(d_oe_n), .data_lines_i(d_i), .ready_busy_n(rdy_n));
	fcui_flash_model i_flash (.ce_n(cs_n), .oe_n(oe_n), .we_n(we_n),
		.reset_powerdown_n(pwrdn_n), .a(addr_q), .hd(d_o), .hd_oe_n(d_oe_n),
		.vpp_ok(vpp_ok), .hv(hv), .dq(d_i), .ready_busy_n(rdy_n));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// One request, held from a falling edge over the taking edge
	task automatic op(input fcui_pkg::fcui_op_t o, input logic [AW-1:0] a,
		input logic [7:0] d);
		@(negedge clk);
		while (req_ready_q !== 1'b1)
			@(negedge clk);
		req_op    = o;
		req_addr  = a;
		req_data  = d;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		// Ready drops on the taking edge; wait two more falling edges before the next request
		repeat (2)
			@(negedge clk);
	endtask : op
	task automatic rd(input logic [AW-1:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		op(fcui_pkg::OP_READ, a, 8'h00);
	endtask : rd
	task automatic settle();
		int n;
		n = 0;
		repeat (12)
			@(negedge clk);
		chk("device_ready_q", {7'h0, device_ready_q}, 8'h00);
		while (device_ready_q !== 1'b1 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		chk("device_ready_q", {7'h0, device_ready_q}, 8'h01);
	endtask : settle
	task automatic wrap_up();
		// A read that never answered leaves its note behind
		chk("pending_reads", 8'(exp_q.size()), 8'h00);
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// ==========================================================
	// Result watcher and hang limit
	always @(negedge clk)
		if (resp_valid_q === 1'b1)
			chk("resp_data_q", resp_data_q, exp_q.pop_front());
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (20)
			@(negedge clk);
		reset = 1'b0;
		rd(21'h0, 8'hff);
		op(fcui_pkg::OP_READ_ID, 21'h0, 8'h00);
		for (int k = 0; k < 4; k++)
			rd(21'(k), k == 0 ? 8'h3c : k == 1 ? 8'h5a : 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			rnd   = xs(rnd);
			av[i] = {5'(i), 12'h0, rnd[3:0]};
			dv[i] = rnd[15:8];
			op(fcui_pkg::OP_PROGRAM, av[i], dv[i]);
			op(fcui_pkg::OP_READ_ARRAY, 21'h0, 8'h00);
			rd(av[i], 8'h00);
			settle();
			rd(av[i], 8'h80);
			op(fcui_pkg::OP_READ_ARRAY, 21'h0, 8'h00);
			rd(av[i], dv[i]);
			rd(av[i], dv[i]);
		end
		op(fcui_pkg::OP_ERASE, av[0], 8'h00);
		settle();
		op(fcui_pkg::OP_READ_ARRAY, 21'h0, 8'h00);
		rd(av[0], 8'hff);
		op(fcui_pkg::OP_LOCK_BLOCK, av[1], 8'h00);
		settle();
		op(fcui_pkg::OP_READ_ID, 21'h0, 8'h00);
		rd({av[1][20:16], 16'h2}, 8'h01);
		op(fcui_pkg::OP_PROGRAM, av[1], 8'h00);
		settle();
		rd(av[1], 8'h82);
		op(fcui_pkg::OP_CLEAR_STATUS, 21'h0, 8'h00);
		op(fcui_pkg::OP_READ_STATUS, 21'h0, 8'h00);
		rd(21'h1f_0000, 8'h80);
		op(fcui_pkg::OP_READ_ARRAY, 21'h0, 8'h00);
		rd(av[1], dv[1]);
		op(fcui_pkg::OP_UNLOCK_ALL, 21'h0, 8'h00);
		settle();
		op(fcui_pkg::OP_READ_ID, 21'h0, 8'h00);
		rd({av[1][20:16], 16'h2}, 8'h00);
		// Master lock needs the override level; a failed try flags status
		op(fcui_pkg::OP_LOCK_MASTER, 21'h0, 8'h00);
		settle();
		rd(21'h0, 8'h90);
		hv = 1'b1;
		op(fcui_pkg::OP_LOCK_MASTER, 21'h0, 8'h00);
		settle();
		hv = 1'b0;
		op(fcui_pkg::OP_READ_ID, 21'h0, 8'h00);
		rd(21'h3, 8'h01);
		op(fcui_pkg::OP_CLEAR_STATUS, 21'h0, 8'h00);
		// Low program supply: the attempt runs but changes nothing
		vpp_ok = 1'b0;
		op(fcui_pkg::OP_PROGRAM, av[2], 8'h00);
		settle();
		rd(av[2], 8'h88);
		vpp_ok = 1'b1;
		op(fcui_pkg::OP_READ_ARRAY, 21'h0, 8'h00);
		rd(av[2], dv[2]);
		// Suspend and resume codes both leave array mode for status
		op(fcui_pkg::OP_SUSPEND, 21'h0, 8'h00);
		rd(av[2], 8'h88);
		op(fcui_pkg::OP_READ_ARRAY, 21'h0, 8'h00);
		op(fcui_pkg::OP_RESUME, 21'h0, 8'h00);
		rd(av[2], 8'h88);
		op(fcui_pkg::OP_READ_STATUS, 21'h0, 8'h00);
		powerdown_req = 1'b1;
		repeat (10)
			@(negedge clk);
		chk("reset_powerdown_n_q", {7'h0, pwrdn_n}, 8'h00);
		powerdown_req = 1'b0;
		rd(av[2], dv[2]);
		op(fcui_pkg::OP_READ_STATUS, 21'h0, 8'h00);
		rd(21'h0, 8'h80);
		repeat (20)
			@(negedge clk);
		wrap_up();
	end
endmodule : test_flash_command_user_interface
`default_nettype wire
